// File: src/uart_config_status_buffers.sv
// Serial channel with configuration, status and data buffers on a plain register port
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module uart_config_status_buffers
  import uart_cfg_pkg::*;
(
  input wire logic sysClk, // 40 MHz system clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic [7:0] regAddr, // Register address
  input wire logic [7:0] regWdata, // Register write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [7:0] regRdata_r, // Read data, cycle after strobe
  input wire logic baseTick, // Base clock enable (gear or low-frequency)
  input wire logic timerAOutput, // Timer output pulse used as base clock
  input wire logic lowPowerEntry, // Pulse on stop/idle/sleep entry
  input wire logic rxdIn, // Serial receive line
  output logic txdOut_r, // Serial transmit line
  output logic txIrq_r // Transmit request pulse
);
  reg_req_t req;
  logic [7:0] ctrl_r, rxCfg_r, baud_r, rxData_r, txData_r, txShift_r;
  logic gateEn_r;
  logic parityErr_r, framingErr_r, overrunErr_r, rxFull_r, txFull_r;
  logic [7:0] divCnt_r;
  logic rtTick;
  logic srcTick;
  logic txBusy, rxBusy;
  logic [7:0] statusWord;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2} rx_state_t;
  tx_state_t txState_r;
  rx_state_t rxState_r;
  logic [4:0] txRt_r, rxRt_r;
  logic [3:0] txBit_r, rxBit_r;
  logic txOdd_r, rxOdd_r;
  logic [7:0] rxShift_r;
  logic rxPar_r;
  logic [9:0] nfCnt_r;
  logic rxFilt_r;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign txBusy = (txState_r != TX_IDLE);
  assign rxBusy = (rxState_r != RX_IDLE);

  // ****************************************
  // Register writes
  // ****************************************

  // Clock gate; resets to zero so software must set it first
  always_ff @(posedge sysClk or posedge reset) begin
    if (reset) begin
      gateEn_r <= 1'b0;
    end else if (req.wr && req.addr == GATE_OFS) begin
      gateEn_r <= req.wdata[0];
    end
  end

  // Control register with per-field write protection
  always_ff @(posedge sysClk or posedge reset) begin
    if (reset) begin
      ctrl_r <= CTRL_RST;
    end else if (lowPowerEntry) begin
      ctrl_r[TXE_BIT] <= 1'b0;
      ctrl_r[RXE_BIT] <= 1'b0;
    end else if (req.wr && req.addr == CTRL_OFS && gateEn_r) begin
      ctrl_r[TXE_BIT] <= req.wdata[TXE_BIT];
      ctrl_r[RXE_BIT] <= req.wdata[RXE_BIT];
      if (!ctrl_r[TXE_BIT] && !txBusy) begin
        ctrl_r[TXSTOP_BIT] <= req.wdata[TXSTOP_BIT];
        ctrl_r[IRDA_BIT] <= req.wdata[IRDA_BIT];
      end
      if (!ctrl_r[TXE_BIT] && !txBusy && !ctrl_r[RXE_BIT] && !rxBusy) begin
        ctrl_r[EVEN_BIT] <= req.wdata[EVEN_BIT];
        ctrl_r[PAR_BIT] <= req.wdata[PAR_BIT];
        ctrl_r[BRG_BIT] <= req.wdata[BRG_BIT];
      end
    end
  end

  // Receive configuration; kept across low power, guarded while operating
  always_ff @(posedge sysClk or posedge reset) begin
    if (reset) begin
      rxCfg_r <= RXCFG_RST;
    end else if (req.wr && req.addr == RXCFG_OFS && gateEn_r) begin
      if (!ctrl_r[TXE_BIT] && !txBusy && !ctrl_r[RXE_BIT] && !rxBusy) begin
        rxCfg_r[RTSEL_LSB+:3] <= req.wdata[RTSEL_LSB+:3];
      end
      if (!ctrl_r[RXE_BIT] && !rxBusy) begin
        rxCfg_r[NOISE_LSB+:2] <= req.wdata[NOISE_LSB+:2];
        rxCfg_r[RXSTOP_BIT] <= req.wdata[RXSTOP_BIT];
      end
    end
  end

  // Baud divider; software is expected to stop both directions first
  always_ff @(posedge sysClk or posedge reset) begin
    if (reset) begin
      baud_r <= BAUD_RST;
    end else if (req.wr && req.addr == BAUD_OFS && gateEn_r) begin
      baud_r <= req.wdata;
    end
  end

  // Transmit buffer shares the address of the receive buffer
  always_ff @(posedge sysClk or posedge reset) begin
    if (reset) begin
      txData_r <= DATA_RST;
    end else if (req.wr && req.addr == DATA_OFS && gateEn_r) begin
      txData_r <= req.wdata;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************

  // Status word; bit 4 tied low
  always_comb begin
    statusWord = 8'h00;
    statusWord[PARITY_ERR_BIT] = parityErr_r;
    statusWord[FRAME_ERR_BIT] = framingErr_r;
    statusWord[OVERRUN_BIT] = overrunErr_r;
    statusWord[RBSY_BIT] = rxBusy;
    statusWord[RXFULL_BIT] = rxFull_r;
    statusWord[TBSY_BIT] = txBusy;
    statusWord[TXFULL_BIT] = txFull_r;
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge sysClk or posedge reset) begin
    if (reset) begin
      regRdata_r <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        CTRL_OFS: regRdata_r <= ctrl_r & 8'hfe;
        RXCFG_OFS: regRdata_r <= {2'b00, rxCfg_r[5:0]};
        BAUD_OFS: regRdata_r <= baud_r;
        STATUS_OFS: regRdata_r <= statusWord;
        DATA_OFS: regRdata_r <= rxData_r;
        GATE_OFS: regRdata_r <= {7'h00, gateEn_r};
        default: regRdata_r <= 8'h00;
      endcase
    end else begin
      regRdata_r <= 8'h00;
    end
  end

  // ****************************************
  // RT clock generation
  // ****************************************

  // Timer source bypasses the divider entirely
  assign srcTick = gateEn_r && (ctrl_r[BRG_BIT] ? timerAOutput : baseTick);
  assign rtTick = srcTick && (ctrl_r[BRG_BIT] || divCnt_r == baud_r);

  always_ff @(posedge sysClk or posedge reset) begin
    if (reset) begin
      divCnt_r <= 8'h00;
    end else if (srcTick) begin
      divCnt_r <= (divCnt_r == baud_r) ? 8'h00 : divCnt_r + 8'h01;
    end
  end

  // RT clocks for one frame bit, odd or even position
  function automatic logic [4:0] bitLen(input logic [2:0] sel, input logic odd);
    unique case (sel)
      3'h0: bitLen = RT16;
      3'h1: bitLen = odd ? RT16 : RT17;
      3'h2: bitLen = RT15;
      3'h3: bitLen = odd ? RT15 : RT16;
      default: bitLen = RT17; // Reserved codes behave as 17
    endcase
  endfunction

  // ****************************************
  // Receive noise filter
  // ****************************************

  // Level must hold for 1,2,4 times divider+1 base clocks to be accepted
  logic [9:0] nfLimit;
  always_comb begin
    unique case (rxCfg_r[NOISE_LSB+:2])
      2'h0: nfLimit = 10'h000;
      2'h1: nfLimit = {2'b00, baud_r};
      2'h2: nfLimit = {1'b0, baud_r, 1'b1};
      default: nfLimit = {baud_r, 2'b11};
    endcase
  end

  always_ff @(posedge sysClk or posedge reset) begin
    if (reset) begin
      rxFilt_r <= 1'b1;
      nfCnt_r <= 10'h000;
    end else if (rxdIn == rxFilt_r) begin
      nfCnt_r <= 10'h000;
    end else if (nfLimit == 10'h000) begin
      rxFilt_r <= rxdIn;
    end else if (srcTick) begin
      if (nfCnt_r >= nfLimit) begin
        rxFilt_r <= rxdIn;
        nfCnt_r <= 10'h000;
      end else begin
        nfCnt_r <= nfCnt_r + 10'h001;
      end
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************

  // Frame: start, eight data, optional parity, one or two stops
  always_ff @(posedge sysClk or posedge reset) begin
    if (reset) begin
      txState_r <= TX_IDLE;
      txRt_r <= RT_RST;
      txBit_r <= 4'h0;
      txOdd_r <= 1'b1;
      txShift_r <= DATA_RST;
      txdOut_r <= 1'b1;
      txFull_r <= 1'b0;
      txIrq_r <= 1'b0;
    end else if (lowPowerEntry) begin
      txState_r <= TX_IDLE;
      txdOut_r <= 1'b1;
      txFull_r <= 1'b0;
      txIrq_r <= 1'b0;
    end else begin
      txIrq_r <= 1'b0;
      if (req.wr && req.addr == DATA_OFS && gateEn_r) begin
        txFull_r <= 1'b1;
      end
      if (txState_r == TX_IDLE) begin
        if (ctrl_r[TXE_BIT] && txFull_r && rtTick) begin
          txShift_r <= txData_r;
          txIrq_r <= 1'b1;
          txFull_r <= (req.wr && req.addr == DATA_OFS && gateEn_r); // Set wins over clear
          txState_r <= TX_START;
          txdOut_r <= 1'b0;
          txOdd_r <= 1'b1;
          txRt_r <= RT_RST;
        end
      end else if (rtTick) begin
        if (txRt_r + 5'h01 < bitLen(rxCfg_r[RTSEL_LSB+:3], txOdd_r)) begin
          txRt_r <= txRt_r + 5'h01;
        end else begin
          txRt_r <= RT_RST;
          txOdd_r <= !txOdd_r;
          unique case (txState_r)
            TX_START: begin
              txState_r <= TX_DATA;
              txBit_r <= 4'h0;
              txdOut_r <= txShift_r[0];
            end
            TX_DATA: begin
              if (txBit_r == DATA_BITS - 4'h1) begin
                txState_r <= ctrl_r[PAR_BIT] ? TX_PAR : TX_STOP1;
                txdOut_r <= ctrl_r[PAR_BIT] ? (^txShift_r ^ !ctrl_r[EVEN_BIT]) : 1'b1;
              end else begin
                txBit_r <= txBit_r + 4'h1;
                txdOut_r <= txShift_r[txBit_r[2:0] + 3'h1];
              end
            end
            TX_PAR: begin
              txState_r <= TX_STOP1;
              txdOut_r <= 1'b1;
            end
            TX_STOP1: txState_r <= ctrl_r[TXSTOP_BIT] ? TX_STOP2 : TX_IDLE;
            TX_STOP2: txState_r <= TX_IDLE;
            default: txState_r <= TX_IDLE;
          endcase
        end
      end
    end
  end

  // ****************************************
  // Receiver
  // ****************************************

  // Samples each bit at its middle RT clock; errors are sticky until low power
  always_ff @(posedge sysClk or posedge reset) begin
    if (reset) begin
      rxState_r <= RX_IDLE;
      rxRt_r <= RT_RST;
      rxBit_r <= 4'h0;
      rxOdd_r <= 1'b1;
      rxShift_r <= DATA_RST;
      rxData_r <= DATA_RST;
      rxPar_r <= 1'b0;
      rxFull_r <= 1'b0;
      parityErr_r <= 1'b0;
      framingErr_r <= 1'b0;
      overrunErr_r <= 1'b0;
    end else if (lowPowerEntry) begin
      rxState_r <= RX_IDLE;
      rxFull_r <= 1'b0;
      parityErr_r <= 1'b0;
      framingErr_r <= 1'b0;
      overrunErr_r <= 1'b0;
    end else begin
      // Reading the buffer empties it; a frame landing the same cycle wins
      if (req.rd && req.addr == DATA_OFS) begin
        rxFull_r <= 1'b0;
      end
      if (rxState_r == RX_IDLE) begin
        if (ctrl_r[RXE_BIT] && !rxFilt_r && rtTick) begin
          rxState_r <= RX_START;
          rxRt_r <= RT_RST;
          rxOdd_r <= 1'b1;
        end
      end else if (rtTick) begin
        if (rxRt_r + 5'h01 < bitLen(rxCfg_r[RTSEL_LSB+:3], rxOdd_r)) begin
          rxRt_r <= rxRt_r + 5'h01;
          if (rxRt_r == RT_RST + 5'h07) begin
            unique case (rxState_r)
              RX_START: if (rxFilt_r) rxState_r <= RX_IDLE; // False start
              RX_DATA: rxShift_r <= {rxFilt_r, rxShift_r[7:1]};
              RX_PAR: rxPar_r <= rxFilt_r;
              RX_STOP1: begin
                if (!rxCfg_r[RXSTOP_BIT]) begin
                  framingErr_r <= framingErr_r | !rxFilt_r;
                end
              end
              RX_STOP2: framingErr_r <= framingErr_r | !rxFilt_r;
              default: ;
            endcase
          end
        end else begin
          rxRt_r <= RT_RST;
          rxOdd_r <= !rxOdd_r;
          unique case (rxState_r)
            RX_START: begin
              rxState_r <= RX_DATA;
              rxBit_r <= 4'h0;
            end
            RX_DATA: begin
              if (rxBit_r == DATA_BITS - 4'h1) begin
                rxState_r <= ctrl_r[PAR_BIT] ? RX_PAR : RX_STOP1;
              end else begin
                rxBit_r <= rxBit_r + 4'h1;
              end
            end
            RX_PAR: rxState_r <= RX_STOP1;
            RX_STOP1: begin
              rxState_r <= rxCfg_r[RXSTOP_BIT] ? RX_STOP2 : RX_IDLE;
              if (ctrl_r[PAR_BIT] && (^rxShift_r ^ rxPar_r ^ !ctrl_r[EVEN_BIT])) begin
                parityErr_r <= 1'b1;
              end
              if (rxFull_r && !(req.rd && req.addr == DATA_OFS)) begin
                overrunErr_r <= 1'b1; // Unread data kept, new frame lost
              end else begin
                rxData_r <= rxShift_r;
                rxFull_r <= 1'b1;
              end
            end
            RX_STOP2: rxState_r <= RX_IDLE;
            default: rxState_r <= RX_IDLE;
          endcase
        end
      end
    end
  end
endmodule

// File: src/uart_cfg_pkg.sv
// Package with register map, field positions and constants of the serial channel
package uart_cfg_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] CTRL_OFS = 8'h1a;
  localparam logic [7:0] RXCFG_OFS = 8'h1b;
  localparam logic [7:0] BAUD_OFS = 8'h1c;
  localparam logic [7:0] STATUS_OFS = 8'h1d;
  localparam logic [7:0] DATA_OFS = 8'h1e;
  localparam logic [7:0] GATE_OFS = 8'h1f;
  // Control register fields
  localparam int TXE_BIT = 7;
  localparam int RXE_BIT = 6;
  localparam int TXSTOP_BIT = 5;
  localparam int EVEN_BIT = 4;
  localparam int PAR_BIT = 3;
  localparam int IRDA_BIT = 2;
  localparam int BRG_BIT = 1;
  // Receive configuration fields
  localparam int RTSEL_LSB = 3;
  localparam int NOISE_LSB = 1;
  localparam int RXSTOP_BIT = 0;
  // Status fields
  localparam int PARITY_ERR_BIT = 7;
  localparam int FRAME_ERR_BIT = 6;
  localparam int OVERRUN_BIT = 5;
  localparam int RBSY_BIT = 3;
  localparam int RXFULL_BIT = 2;
  localparam int TBSY_BIT = 1;
  localparam int TXFULL_BIT = 0;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RXCFG_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [4:0] RT_RST = 5'h00;
  // RT clock counts per frame bit
  localparam logic [4:0] RT15 = 5'h0f;
  localparam logic [4:0] RT16 = 5'h10;
  localparam logic [4:0] RT17 = 5'h11;
  localparam logic [3:0] DATA_BITS = 4'h8;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// File: testbench/uart_cfg_asserts.sv
// Checker of register port and serial line relations
`timescale 1ns/10ps
module uart_cfg_asserts
  import uart_cfg_pkg::*;
(
  input wire logic sysClk, // System clock
  input wire logic reset, // Async reset
  input wire logic [7:0] regAddr, // Address
  input wire logic [7:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  input wire logic [7:0] regRdata_r, // Read data
  input wire logic lowPowerEntry, // Low-power pulse
  input wire logic txdOut_r, // Serial out
  input wire logic txIrq_r // Transmit request
);
  // ********************
  // Properties
  // ********************
  // Single clock domain, so clock and reset are given once
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (reset);
  property p_rd_idle; !regRd |=> regRdata_r == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_cfg_top; regRd && regAddr == RXCFG_OFS |=> regRdata_r[7:6] == 2'b00; endproperty
  a_cfg_top: assert property (p_cfg_top) else $error("config top bits set");
  property p_bit4; regRd && regAddr == STATUS_OFS |=> regRdata_r[4] == 1'b0; endproperty
  a_bit4: assert property (p_bit4) else $error("status bit 4 set");
  property p_unmap; regRd && regAddr > GATE_OFS |=> regRdata_r == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_irq; txIrq_r |=> !txIrq_r; endproperty
  a_irq: assert property (p_irq) else $error("transmit request too long");
  // Start bit must follow the hand-over to the shifter promptly
  property p_start; txIrq_r |-> ##[0:40] !txdOut_r; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_lp;
    lowPowerEntry ##1 (regRd && regAddr == STATUS_OFS) |=> regRdata_r == 8'h00;
  endproperty
  a_lp: assert property (p_lp) else $error("status kept on low power");
  property p_gate;
    regWr && regAddr == GATE_OFS ##2 (regRd && regAddr == GATE_OFS)
      |=> regRdata_r[0] == $past(regWdata[0], 3);
  endproperty
  a_gate: assert property (p_gate) else $error("gate bit not stored");
endmodule

// File: testbench/serial_peer.sv
// Remote serial transceiver model facing the channel's line
`timescale 1ns/10ps
module serial_peer #(
  parameter int BIT_CYC = 16 // System clocks per frame bit
) (
  input wire logic clk, // System clock
  input wire logic txd, // Line from the channel
  output logic rxd, // Line into the channel
  output logic [7:0] lastByte, // Last frame caught
  output int frameCount // Frames caught
);
  initial begin
    rxd = 1'b1;
    lastByte = 8'h00;
    frameCount = 0;
  end
  // Sender; the idle high tail doubles as a second stop bit
  task automatic send(input logic [7:0] dat, input logic stop1);
    logic [9:0] bits;
    bits = {stop1, dat, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= bits[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge clk);
  endtask
  // Catcher samples mid-bit, so a boundary off by a cycle still reads right
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      lastByte[i] = txd;
    end
    repeat (BIT_CYC) @(posedge clk);
    frameCount++;
  end
endmodule

// File: testbench/tb_uart_config_status_buffers.sv
// Testbench of the serial channel register block against a small behavioural model
`timescale 1ns/10ps
module tb_uart_config_status_buffers
  import uart_cfg_pkg::*;
();
  logic sysClk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic baseTick = 1'b0;
  logic timerAOutput = 1'b0;
  logic lowPowerEntry = 1'b0;
  logic [7:0] regRdata_r;
  logic rxdIn;
  logic txdOut_r;
  logic txIrq_r;
  logic [7:0] lastByte;
  logic [31:0] seed = 32'hca9c;
  logic [7:0] v;
  logic [7:0] d;
  logic [7:0] e;
  logic tmrFast = 1'b0;
  logic [7:0] sentQ[$];
  int frameCount;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int cfgM = 0;
  uart_config_status_buffers uut (.sysClk(sysClk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r),
    .baseTick(baseTick), .timerAOutput(timerAOutput), .lowPowerEntry(lowPowerEntry),
    .rxdIn(rxdIn), .txdOut_r(txdOut_r), .txIrq_r(txIrq_r));
  serial_peer #(.BIT_CYC(16)) peer (.clk(sysClk), .txd(txdOut_r), .rxd(rxdIn),
    .lastByte(lastByte), .frameCount(frameCount));
  // ********************
  // Clock, watchdog, helpers
  // ********************
  always #12.5 sysClk = ~sysClk;
  // Watchdog; timer ticks only matter when the timer source is chosen
  always @(posedge sysClk) begin
    cyc <= cyc + 1;
    timerAOutput <= tmrFast | cyc[2];
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Write leaves one idle cycle so strobes are never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    regAddr <= a;
    regWdata <= w;
    regWr <= 1'b1;
    @(posedge sysClk);
    regWr <= 1'b0;
    @(posedge sysClk);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sysClk);
    regRd <= 1'b0;
    @(negedge sysClk);
    v = regRdata_r;
    @(posedge sysClk);
  endtask
  task automatic complete_run();
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ********************
  // Main sequence
  // ********************
  initial begin
    repeat (2) @(posedge sysClk);
    reset <= 1'b0;
    @(posedge sysClk);
    for (int a = 26; a <= 32; a++) begin
      rd(8'(a));
      chk(v, 8'h00);
    end
    wr(RXCFG_OFS, 8'h3f);
    rd(RXCFG_OFS);
    chk(v, 8'h00);
    wr(GATE_OFS, 8'h01);
    rd(GATE_OFS);
    chk(v & 8'h01, 8'h01);
    // Every count code and filter code, junk in the top bits
    for (int k = 0; k < 8; k++) begin
      d = rnd();
      cfgM = {3'(k), 2'(k), d[0]};
      wr(RXCFG_OFS, {d[7:6], 6'(cfgM)});
      rd(RXCFG_OFS);
      chk(v, 8'(cfgM));
    end
    d = rnd();
    wr(BAUD_OFS, d);
    rd(BAUD_OFS);
    chk(v, d);
    wr(CTRL_OFS, 8'h40);
    wr(RXCFG_OFS, ~8'(cfgM));
    rd(RXCFG_OFS);
    chk(v, 8'(cfgM));
    wr(CTRL_OFS, 8'h00);
    wr(BAUD_OFS, 8'h00);
    wr(RXCFG_OFS, 8'h01);
    wr(CTRL_OFS, 8'hc0);
    d = rnd();
    wr(DATA_OFS, d);
    sentQ.push_back(d);
    rd(STATUS_OFS);
    chk(v & 8'h03, 8'h01);
    baseTick <= 1'b1;
    for (int k = 0; k < 50 && txIrq_r !== 1'b1; k++) @(negedge sysClk);
    chk({7'h00, txIrq_r}, 8'h01);
    @(posedge sysClk);
    rd(STATUS_OFS);
    chk(v & 8'h03, 8'h02);
    for (int k = 0; k < 300 && frameCount == 0; k++) @(posedge sysClk);
    chk(lastByte, sentQ.pop_front());
    repeat (24) @(posedge sysClk);
    rd(STATUS_OFS);
    chk(v & 8'h02, 8'h00);
    // Bad first stop with two stops selected must pass
    d = rnd();
    fork
      peer.send(d, 1'b0);
      begin
        repeat (40) @(posedge sysClk);
        rd(STATUS_OFS);
        chk(v & 8'h08, 8'h08);
      end
    join
    repeat (8) @(posedge sysClk);
    rd(STATUS_OFS);
    chk(v & 8'h4c, 8'h04);
    rd(DATA_OFS);
    chk(v, d);
    rd(STATUS_OFS);
    chk(v & 8'h04, 8'h00);
    wr(CTRL_OFS, 8'h80);
    wr(RXCFG_OFS, 8'h00);
    wr(CTRL_OFS, 8'hc0);
    d = rnd();
    peer.send(d, 1'b0);
    rd(STATUS_OFS);
    chk(v & 8'h40, 8'h40);
    // Wrong even parity into a still-full buffer; the tenth slot is parity here
    wr(CTRL_OFS, 8'h00);
    wr(CTRL_OFS, 8'h58);
    e = rnd();
    peer.send(e, ~^e);
    repeat (4) @(posedge sysClk);
    rd(STATUS_OFS);
    chk(v & 8'he4, 8'he4);
    rd(DATA_OFS);
    chk(v, d);
    // Low-power entry with flags pending and settings loaded
    wr(CTRL_OFS, 8'h00);
    d = rnd() | 8'h01;
    wr(BAUD_OFS, d);
    wr(RXCFG_OFS, 8'h1d);
    wr(CTRL_OFS, 8'hd8);
    lowPowerEntry <= 1'b1;
    @(posedge sysClk);
    lowPowerEntry <= 1'b0;
    rd(STATUS_OFS);
    chk(v, 8'h00);
    rd(BAUD_OFS);
    chk(v, d);
    rd(RXCFG_OFS);
    chk(v, 8'h1d);
    rd(CTRL_OFS);
    chk(v, 8'h18);
    // Timer as base clock: a non-zero divider must not stretch the bits
    wr(RXCFG_OFS, 8'h00);
    wr(CTRL_OFS, 8'h82);
    tmrFast <= 1'b1;
    d = rnd();
    wr(DATA_OFS, d);
    sentQ.push_back(d);
    for (int k = 0; k < 300 && frameCount < 2; k++) @(posedge sysClk);
    chk(lastByte, sentQ.pop_front());
    complete_run();
  end
endmodule
bind uart_config_status_buffers uart_cfg_asserts chkr (.sysClk(sysClk), .reset(reset),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata_r(regRdata_r), .lowPowerEntry(lowPowerEntry), .txdOut_r(txdOut_r),
  .txIrq_r(txIrq_r));
